// File: logic/spi_master_slave_port.sv
// Byte-wide full-duplex SPI port that acts as master or slave.
// Assumes all pin inputs are asynchronous to ref_clk and that the
// surrounding pad logic resolves the wire from the *_oe enables.
//
// Summary of operation
// - Port off releases all four serial pins to ordinary port use.
// - Selected slave drives MISO only while slave select is low or ignored.
// - Slave select low clears master bit when not ignored.
// - Idle master floats MOSI and clock; drives them only during a transfer.
// - Phase zero slave: data write while selected is a write collision.
// - Phase one allows slave select held low across bytes.
// - Master starts clock and transfer when data is written.
// - First master bit appears half a bit time after write.
// - After one byte, stop clock, set done flag, raise interrupt if enabled.
// - Both ends shift simultaneously, exchanging their bytes as one ring.
// - Demoted master turns MOSI and clock to inputs, MISO to output.
// - Demotion also sets done flag and requests interrupt if enabled.
// - After demotion only software restores master mode.
// - Write during transfer sets collision flag; the written byte is dropped.
// - Completed byte moves to read buffer, overwriting any unread byte.
// - Writing one to collision flag clears it.
// - Serial clock rate comes from core clock via rate_select prescaler.
// - With select ignored, master bit alone sets role.
// - Phase one changes on leading edge; phase zero samples on leading edge.
// - Polarity one idles clock high; polarity zero idles it low.
// - Bit order one sends LSB first, zero sends MSB first.
`timescale 1ns/1ps

module spi_master_slave_port
   import spi_port_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   input  wire spi_config_type config_bits,
   input  wire logic           spi_irq_enable,
   input  wire logic           master_write,
   input  wire logic           master_write_value,
   input  wire logic           data_write,
   input  wire logic [7:0]     data_write_value,
   input  wire logic           clear_done,
   input  wire logic           clear_collision,
   input  wire logic           ss_in,
   input  wire logic           miso_in,
   input  wire logic           mosi_in,
   input  wire logic           sclk_in,
   output pin_drive_type       pin_drive,
   output logic                pins_released,
   output logic                master_select_bit,
   output logic                transfer_done_flag,
   output logic                write_collision_flag,
   output logic                spi_irq,
   output logic [7:0]          read_data
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_filt;

   assign pin_raw[PIN_SS]   = ss_in;
   assign pin_raw[PIN_MISO] = miso_in;
   assign pin_raw[PIN_MOSI] = mosi_in;
   assign pin_raw[PIN_SCLK] = sclk_in;

   // Three stages; the filtered level moves only when stages two and three agree
   for (genvar gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      logic [2:0] stage;
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            stage          <= SYNC_RESET;
            pin_filt[gi]   <= SYNC_RESET[0];
         end else begin
            stage <= {stage[1:0], pin_raw[gi]};
            if (stage[1] == stage[2]) begin
               pin_filt[gi] <= stage[2];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Role selection
   // ----------------------------------------------------------------------
   logic ss_low;
   logic master_mode;
   logic slave_mode;
   logic slave_selected;
   logic demote;

   assign ss_low = ~pin_filt[PIN_SS];
   // Pin ignored when select_ignore is set: master bit alone decides
   assign master_mode = config_bits.spi_on & master_select_bit
                      & (config_bits.select_ignore | ~ss_low);
   assign slave_mode  = config_bits.spi_on & ~master_mode;
   assign slave_selected = slave_mode & (config_bits.select_ignore | ss_low);
   // Another master pulling select low forces this end to slave
   assign demote = config_bits.spi_on & ~config_bits.select_ignore
                 & master_select_bit & ss_low;

   // Master bit: software write sets it, demotion clears it, never self-restored
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         master_select_bit <= MASTER_RESET;
      end else if (master_write) begin
         master_select_bit <= master_write_value;
      end else if (demote) begin
         master_select_bit <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Prescaler and master sequencer
   // ----------------------------------------------------------------------
   master_state_type master_state;
   logic [6:0]       half_div;
   logic [6:0]       div_count;
   logic             half_tick;
   logic [4:0]       half_edges;
   logic             sclk_level;
   logic             master_busy;
   logic             start_master;

   // Half bit-time in core clocks, chosen by rate_select
   always_comb begin
      case (config_bits.rate_select)
         2'h0:    half_div = HALF_DIV_00;
         2'h1:    half_div = HALF_DIV_01;
         2'h2:    half_div = HALF_DIV_10;
         default: half_div = HALF_DIV_11;
      endcase
   end

   assign half_tick    = (master_state != MASTER_IDLE) && (div_count == half_div - 7'h01);
   assign master_busy  = (master_state != MASTER_IDLE);
   // Only an enabled master may start a transfer, and only when idle
   assign start_master = data_write & master_mode & ~master_busy;

   // Divider restarts on every start so the first edge lands at a fixed time
   always_ff @(posedge ref_clk) begin
      if (!rst_n || start_master || !master_busy || half_tick) begin
         div_count <= 7'h00;
      end else begin
         div_count <= div_count + 7'h01;
      end
   end

   logic master_finish;
   assign master_finish = (master_state == MASTER_RUN) && half_tick
                        && (half_edges == LAST_HALF_EDGE);
   // Start waits half a bit, then sixteen clock edges, then the clock stops
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         master_state <= MASTER_IDLE;
         half_edges   <= 5'h00;
         sclk_level   <= 1'b0;
      end else if (demote || !config_bits.spi_on) begin
         master_state <= MASTER_IDLE;               // Demotion aborts the byte
         half_edges   <= 5'h00;
         sclk_level   <= config_bits.clock_polarity;
      end else begin
         case (master_state)
            MASTER_IDLE: begin
               sclk_level <= config_bits.clock_polarity;
               half_edges <= 5'h00;
               if (start_master) begin
                  master_state <= MASTER_START;
               end
            end
            MASTER_START: begin
               // First data bit is on MOSI after this half bit
               if (half_tick) begin
                  master_state <= MASTER_RUN;
               end
            end
            MASTER_RUN: begin
               if (half_tick) begin
                  sclk_level <= ~sclk_level;
                  half_edges <= half_edges + 5'h01;
                  if (master_finish) begin
                     master_state <= MASTER_IDLE;   // Clock generator stops
                  end
               end
            end
            default: master_state <= MASTER_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Edge events, shared by both roles
   // ----------------------------------------------------------------------
   logic sclk_seen;
   logic slave_lead;
   logic slave_trail;
   logic lead_edge;
   logic trail_edge;
   logic sample_edge;
   logic drive_edge;
   logic rx_in;

   // Previous filtered clock level for the slave edge detector
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sclk_seen <= SYNC_RESET[0];   // Same level as the filter, so no edge at reset
      end else begin
         sclk_seen <= pin_filt[PIN_SCLK];
      end
   end

   // Leading edge leaves the idle level, trailing edge returns to it
   assign slave_lead  = slave_selected && (sclk_seen == config_bits.clock_polarity)
                      && (pin_filt[PIN_SCLK] != config_bits.clock_polarity);
   assign slave_trail = slave_selected && (sclk_seen != config_bits.clock_polarity)
                      && (pin_filt[PIN_SCLK] == config_bits.clock_polarity);
   assign lead_edge   = master_mode ? (master_state == MASTER_RUN && half_tick
                                       && !half_edges[0]) : slave_lead;
   assign trail_edge  = master_mode ? (master_state == MASTER_RUN && half_tick
                                       && half_edges[0]) : slave_trail;
   // Phase one drives on leading and samples on trailing; phase zero the reverse
   assign sample_edge = config_bits.clock_phase ? trail_edge : lead_edge;
   assign drive_edge  = config_bits.clock_phase ? lead_edge  : trail_edge;
   assign rx_in       = master_mode ? pin_filt[PIN_MISO] : pin_filt[PIN_MOSI];

   // ----------------------------------------------------------------------
   // Shift path
   // ----------------------------------------------------------------------
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic [7:0] next_rx;
   logic [3:0] bit_count;
   logic [2:0] sample_pos;
   logic [2:0] drive_pos;
   logic       slave_finish;
   logic       finish;
   logic       slave_busy;
   logic       transfer_busy;
   logic       collision;

   // Bit position within the byte follows the chosen bit order
   assign sample_pos = config_bits.bit_order_select ? bit_count[2:0]
                                                    : 3'(LAST_BIT_INDEX - bit_count);
   assign drive_pos  = sample_pos;

   always_comb begin
      next_rx = rx_byte;
      if (sample_edge && bit_count <= LAST_BIT_INDEX) begin
         next_rx[sample_pos] = rx_in;
      end
   end

   assign slave_finish  = slave_mode && sample_edge && (bit_count == LAST_BIT_INDEX);
   assign finish        = master_finish | slave_finish;
   // Phase zero slave is busy while selected; phase one may stay selected
   assign slave_busy    = slave_mode && ((bit_count != 4'h0)
                        || (!config_bits.clock_phase && !config_bits.select_ignore && ss_low));
   assign transfer_busy = master_busy | slave_busy;
   assign collision     = data_write && config_bits.spi_on && transfer_busy;

   // Sample counter; a deselected slave starts over at the next select
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bit_count <= 4'h0;
      end else if (finish || demote || start_master || (slave_mode && !slave_selected)) begin
         bit_count <= 4'h0;
      end else if (sample_edge && bit_count <= LAST_BIT_INDEX) begin
         bit_count <= bit_count + 4'h1;
      end
   end

   // Received bits collect separately until the byte is whole
   always_ff @(posedge ref_clk) begin
      if (!rst_n || start_master) begin
         rx_byte <= DATA_RESET;
      end else begin
         rx_byte <= next_rx;
      end
   end

   // Transmit byte: loaded by a clean write, swapped for the received byte
   // at the end so both ends exchange contents like one ring
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_byte <= DATA_RESET;
      end else if (finish) begin
         tx_byte <= next_rx;
      end else if (data_write && !transfer_busy) begin
         tx_byte <= data_write_value;                // Colliding byte never lands
      end
   end

   // Read buffer is overwritten by each finished byte, read or not
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         read_data <= DATA_RESET;
      end else if (finish) begin
         read_data <= next_rx;
      end
   end

   // ----------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------
   logic next_done;
   logic next_collision;

   // A setting event wins over a clear in the same cycle
   assign next_done      = finish | demote | (transfer_done_flag & ~clear_done);
   assign next_collision = collision | (write_collision_flag & ~clear_collision);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         transfer_done_flag <= FLAG_RESET;
         spi_irq            <= FLAG_RESET;
      end else begin
         transfer_done_flag <= next_done;
         spi_irq            <= next_done & spi_irq_enable;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         write_collision_flag <= FLAG_RESET;
      end else begin
         write_collision_flag <= next_collision;
      end
   end

   // ----------------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------------
   logic data_bit;

   // Data line bit: preloaded while waiting, advanced on each drive edge
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         data_bit <= 1'b0;
      end else if (bit_count == 4'h0 && !(config_bits.clock_phase && drive_edge)) begin
         data_bit <= tx_byte[drive_pos];
      end else if (drive_edge && bit_count <= LAST_BIT_INDEX) begin
         data_bit <= tx_byte[drive_pos];
      end
   end

   // Enables settle one cycle after the role changes, which the pads tolerate
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_drive     <= '0;
         pins_released <= 1'b1;
      end else begin
         pins_released      <= ~config_bits.spi_on;
         pin_drive.sclk_out <= master_mode ? sclk_level : config_bits.clock_polarity;
         pin_drive.mosi_out <= data_bit;
         pin_drive.miso_out <= data_bit;
         // Master drives MOSI and clock only once the transfer has begun
         pin_drive.mosi_oe  <= master_mode && master_state == MASTER_RUN
                              || master_mode && master_state == MASTER_START
                                 && half_tick;
         pin_drive.sclk_oe  <= master_mode && master_state == MASTER_RUN
                              && !master_finish;
         // Slave drives MISO only while selected; all off when disabled
         pin_drive.miso_oe  <= slave_selected && !demote;
      end
   end

endmodule

// File: logic/spi_port_pkg.sv
// Shared constants and carrier types for the byte-wide SPI master/slave port.
// Assumes a single 100 MHz core clock and a synchronous active-low reset.
package spi_port_pkg;

   // ----------------------------------------------------------------------
   // Clock and prescaler
   // ----------------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 10;              // ref_clk period in ns
   // Core clocks per serial bit for each rate_select code
   localparam int RATE_DIV_00     = 4;
   localparam int RATE_DIV_01     = 16;
   localparam int RATE_DIV_10     = 64;
   localparam int RATE_DIV_11     = 128;
   localparam logic [6:0] HALF_DIV_00 = 7'(RATE_DIV_00 / 2);
   localparam logic [6:0] HALF_DIV_01 = 7'(RATE_DIV_01 / 2);
   localparam logic [6:0] HALF_DIV_10 = 7'(RATE_DIV_10 / 2);
   localparam logic [6:0] HALF_DIV_11 = 7'(RATE_DIV_11 / 2);

   // ----------------------------------------------------------------------
   // Transfer shape
   // ----------------------------------------------------------------------
   localparam int          BYTE_BITS      = 8;
   localparam logic [3:0]  LAST_BIT_INDEX = 4'h7;
   localparam logic [4:0]  LAST_HALF_EDGE = 5'h0F;   // 16 serial clock edges per byte

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] DATA_RESET     = 8'h00;
   localparam logic       FLAG_RESET     = 1'b0;
   localparam logic       MASTER_RESET   = 1'b0;
   localparam logic [2:0] SYNC_RESET     = 3'h7;     // Pins idle high after reset

   // Pin order inside the synchroniser bank
   localparam int PIN_SS   = 0;
   localparam int PIN_MISO = 1;
   localparam int PIN_MOSI = 2;
   localparam int PIN_SCLK = 3;
   localparam int PIN_COUNT = 4;

   // Static configuration bits steered by software
   typedef struct packed {
      logic       spi_on;
      logic       select_ignore;
      logic       clock_polarity;
      logic       clock_phase;
      logic       bit_order_select;
      logic [1:0] rate_select;
   } spi_config_type;

   // Drive side of the three data/clock pins
   typedef struct packed {
      logic miso_out;
      logic miso_oe;
      logic mosi_out;
      logic mosi_oe;
      logic sclk_out;
      logic sclk_oe;
   } pin_drive_type;

   typedef enum logic [1:0] {
      MASTER_IDLE,
      MASTER_START,
      MASTER_RUN
   } master_state_type;

endpackage

// File: testbench/spi_port_chk.sv
// Concurrent checks on the ports of the SPI master/slave port.
// Assumes one ref_clk domain and the synchronous active-low rst_n.
`timescale 1ns/1ps

module spi_port_chk
   import spi_port_pkg::*;
(
   input wire logic           ref_clk,
   input wire logic           rst_n,
   input wire spi_config_type config_bits,
   input wire logic           spi_irq_enable,
   input wire logic           master_write,
   input wire logic           data_write,
   input wire logic           clear_done,
   input wire logic           clear_collision,
   input wire logic           ss_in,
   input wire pin_drive_type  pin_drive,
   input wire logic           pins_released,
   input wire logic           master_select_bit,
   input wire logic           transfer_done_flag,
   input wire logic           write_collision_flag,
   input wire logic           spi_irq
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_off_release:
   assert property (!config_bits.spi_on |=> pins_released && !pin_drive.miso_oe
      && !pin_drive.mosi_oe && !pin_drive.sclk_oe) else $error("pins kept while off");
   a_miso_unselected:
   assert property ((config_bits.spi_on && !config_bits.select_ignore
      && !master_select_bit && ss_in)[*7] |-> !pin_drive.miso_oe)
      else $error("miso driven while unselected");
   // Filter delay of ss is covered by the seven-cycle run
   a_demote_clear:
   assert property ((config_bits.spi_on && !config_bits.select_ignore && !ss_in
      && !master_write)[*7] |-> !master_select_bit) else $error("master kept on select");
   a_slave_quiet:
   assert property ((!master_select_bit)[*3] |-> !pin_drive.mosi_oe && !pin_drive.sclk_oe)
      else $error("slave drives mosi or clock");
   a_write_starts:
   assert property (data_write && master_select_bit && config_bits.spi_on
      && config_bits.select_ignore && !pin_drive.sclk_oe |-> ##[1:200] pin_drive.sclk_oe)
      else $error("write did not start master");
   a_done_at_end:
   assert property ($fell(pin_drive.sclk_oe) && config_bits.spi_on
      |-> ##[0:2] transfer_done_flag) else $error("no done after transfer");
   a_done_sticky:
   assert property (transfer_done_flag && !clear_done |=> transfer_done_flag)
      else $error("done flag lost");
   a_irq_gate:
   assert property ($stable(transfer_done_flag) && $stable(spi_irq_enable)
      |-> spi_irq == (transfer_done_flag && spi_irq_enable)) else $error("irq mismatch");
   a_coll_busy:
   assert property (data_write && pin_drive.sclk_oe |=> write_collision_flag)
      else $error("no collision on busy write");
   a_coll_clear:
   assert property (write_collision_flag && clear_collision && !data_write
      |=> !write_collision_flag) else $error("collision not cleared");

   c_done: cover property ($rose(transfer_done_flag));
   c_demote: cover property ($fell(master_select_bit));
   c_coll: cover property ($rose(write_collision_flag));
endmodule

bind spi_master_slave_port spi_port_chk u_chk (.ref_clk, .rst_n, .config_bits,
   .spi_irq_enable, .master_write, .data_write, .clear_done, .clear_collision, .ss_in,
   .pin_drive, .pins_released, .master_select_bit, .transfer_done_flag,
   .write_collision_flag, .spi_irq);

// File: testbench/spi_far_end.sv
// Far-side SPI device: slave to the port as master, or master on request.
// Assumes clock_polarity 0, clock_phase 1 and a board pull-down on the clock.
`timescale 1ns/1ps

module spi_far_end (
   input  wire logic  ref_clk,
   input  wire logic  sclk,
   input  wire logic  mosi,
   input  wire logic  miso,
   input  wire logic  lsb_first,
   output logic       miso_out,
   output logic       sclk_out,
   output logic       sclk_en,
   output logic       mosi_out,
   output logic       ss_n,
   output logic [7:0] rx_byte
);
   logic [7:0] shreg = 8'h00;
   int         bit_cnt = 0;

   initial {miso_out, sclk_out, sclk_en, mosi_out, ss_n, rx_byte} = 13'h100;

   task automatic load(input logic [7:0] b);
      shreg = b;
      bit_cnt = 0;
   endtask

   task automatic select(input logic v);
      ss_n = v;
   endtask

   // Slave: change on the leading edge, sample on the trailing one
   always @(posedge sclk) if (!sclk_en)
      miso_out = lsb_first ? shreg[0] : shreg[7];
   always @(negedge sclk) if (!sclk_en) begin
      shreg = lsb_first ? {mosi, shreg[7:1]} : {shreg[6:0], mosi};
      bit_cnt++;
      if (bit_cnt == 8) begin
         rx_byte = shreg;
         miso_out = ~miso_out; // Released line must not keep the last bit
      end
   end

   // Master: select, eight slow clock pulses, then select left as ss_end gives it
   task automatic run_master(input logic [7:0] b, input logic ss_end);
      shreg = b;
      ss_n = 1'b0;
      sclk_en = 1'b1;
      repeat (12) @(negedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         sclk_out = 1'b1;
         mosi_out = lsb_first ? shreg[0] : shreg[7];
         repeat (10) @(negedge ref_clk);
         sclk_out = 1'b0;
         shreg = lsb_first ? {miso, shreg[7:1]} : {shreg[6:0], miso};
         repeat (10) @(negedge ref_clk);
      end
      rx_byte = shreg;
      ss_n = ss_end; // Held low only when another byte follows at once
      sclk_en = 1'b0;
      mosi_out = ~mosi_out;
   endtask
endmodule

// File: testbench/spi_master_slave_port_bench.sv
// Self-checking bench for the SPI master/slave port against a far-side model.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ps

module spi_master_slave_port_bench;
   import spi_port_pkg::*;

   logic           ref_clk = 1'b0;
   logic           rst_n = 1'b0;
   spi_config_type cfg = '0;
   logic           irq_en = 1'b0;
   logic           mw = 1'b0;
   logic           mwv = 1'b0;
   logic           dw = 1'b0;
   logic [7:0]     dwv = 8'h00;
   logic           clr_done = 1'b0;
   logic           clr_coll = 1'b0;
   pin_drive_type  pd;
   logic           rel, msb, done, coll, irq, sclk, mosi, miso;
   logic           f_miso, f_sclk, f_sclk_en, f_mosi, f_ss_n;
   logic [7:0]     rdata, tx, fb, f_rx;
   logic [7:0]     exp_q[$];
   int             mismatches = 0;
   int             cmp_count = 0;
   int             seed = 32'h52CA;
   int             cyc;
   always #5 ref_clk = ~ref_clk;
   // Wire levels: clock falls to its pull-down when nobody drives it
   assign sclk = pd.sclk_oe ? pd.sclk_out : (f_sclk_en ? f_sclk : 1'b0);
   assign mosi = pd.mosi_oe ? pd.mosi_out : f_mosi;
   assign miso = pd.miso_oe ? pd.miso_out : f_miso;

   spi_master_slave_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .config_bits(cfg),
      .spi_irq_enable(irq_en), .master_write(mw), .master_write_value(mwv),
      .data_write(dw), .data_write_value(dwv), .clear_done(clr_done),
      .clear_collision(clr_coll), .ss_in(f_ss_n), .miso_in(miso), .mosi_in(mosi),
      .sclk_in(sclk), .pin_drive(pd), .pins_released(rel), .master_select_bit(msb),
      .transfer_done_flag(done), .write_collision_flag(coll), .spi_irq(irq),
      .read_data(rdata));
   spi_far_end far (.ref_clk(ref_clk), .sclk(sclk), .mosi(mosi), .miso(miso),
      .lsb_first(cfg.bit_order_select), .miso_out(f_miso), .sclk_out(f_sclk),
      .sclk_en(f_sclk_en), .mosi_out(f_mosi), .ss_n(f_ss_n), .rx_byte(f_rx));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] v);
      @(negedge ref_clk);
      dwv = v;
      dw = 1'b1;
      @(negedge ref_clk);
      dw = 1'b0;
   endtask

   task automatic clr;
      @(negedge ref_clk);
      clr_done = 1'b1;
      clr_coll = 1'b1;
      @(negedge ref_clk);
      clr_done = 1'b0;
      clr_coll = 1'b0;
   endtask

   // Completion is waited for under a bound; a hang ends the run
   task automatic wait_done;
      cyc = 0;
      while (done !== 1'b1 && cyc < 3000) begin
         @(negedge ref_clk);
         cyc++;
      end
      if (cyc >= 3000) begin
         mismatches++;
         stop_test();
      end
   endtask

   // Each rise of the done flag retires the oldest expected byte
   always @(posedge done) begin
      @(negedge ref_clk);
      if (exp_q.size() > 0)
         check("read_data", rdata, exp_q.pop_front());
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      tick(5);
      rst_n = 1'b1;
      tick(4);
      check("reset", {rel, done, coll, msb}, 8'h08);
      cfg = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1};
      mwv = 1'b1;
      @(negedge ref_clk);
      mw = 1'b1;
      @(negedge ref_clk);
      mw = 1'b0;
      tick(2);
      check("master", {rel, msb}, 8'h01);
      // Master bytes in both orders at two rates, each hit by a collision
      for (int k = 0; k < 4; k++) begin
         cfg.bit_order_select = k[0];
         cfg.rate_select = k[1] ? 2'h2 : 2'h1;
         irq_en = k[0];
         tx = 8'($random(seed));
         fb = 8'($random(seed));
         far.load(fb);
         exp_q.push_back(fb);
         wr(tx);
         cyc = 0;
         while (pd.mosi_oe !== 1'b1 && cyc < 300) begin
            @(negedge ref_clk);
            cyc++;
         end
         fb = 8'(cyc >= (k[1] ? 31 : 7) && cyc <= (k[1] ? 66 : 18));
         check("start_gap", fb, 8'h01);
         if (cyc >= 300) stop_test();
         wr(~tx);
         wait_done();
         tick(2);
         check("far_rx", f_rx, tx);
         check("coll_irq", {coll, irq}, {6'h00, 1'b1, irq_en});
         clr();
         check("cleared", {done, coll}, 8'h00);
      end
      // Select pulled low while idle as master
      cfg.select_ignore = 1'b0;
      far.select(1'b0);
      tick(8);
      check("demoted", {msb, done}, 8'h01);
      check("demote_pins", {pd.miso_oe, pd.mosi_oe, pd.sclk_oe}, 8'h04);
      far.select(1'b1);
      clr();
      tick(8);
      check("stays_slave", msb, 8'h00);
      // Slave bytes with select kept low between them, each checked in read_data
      for (int k = 0; k < 2; k++) begin
         tx = 8'($random(seed));
         fb = 8'($random(seed));
         wr(tx);
         exp_q.push_back(fb);
         far.run_master(fb, k[0]); // Select stays low after the first byte
         tick(8);
         check("slave_tx", f_rx, tx);
         check("miso_oe", pd.miso_oe, 8'(k == 0));
         clr();
      end
      cfg.clock_phase = 1'b0; // Select ignore already clear
      far.select(1'b0);
      tick(8);
      wr(8'h5A);
      check("ph0_coll", coll, 8'h01);
      far.select(1'b1);
      cfg.spi_on = 1'b0;
      tick(2);
      check("off", {rel, pd.miso_oe, pd.mosi_oe, pd.sclk_oe}, 8'h08);
      stop_test();
   end
endmodule
